// file: shared/tsense_pkg.sv
// constants used by the device end of the sensor chain link and by the bench
// assumes a 10 MHz clock on both ends
package tsense_pkg;
    localparam int unsigned CLOCK_HZ             = 10_000_000;
    // command byte fields
    localparam int unsigned CMD_SCOPE_POS        = 7;
    localparam int unsigned CMD_ID_LSB           = 3;
    localparam int unsigned CMD_PTR_LSB          = 1;
    localparam int unsigned CMD_RW_POS           = 0;
    // register pointers
    localparam logic [1:0]  PTR_TEMP             = 2'h0;
    localparam logic [1:0]  PTR_CONFIG           = 2'h1;
    localparam logic [1:0]  PTR_LOW              = 2'h2;
    localparam logic [1:0]  PTR_HIGH             = 2'h3;
    // configuration fields
    localparam int unsigned CFG_INT_EN_POS       = 7;
    localparam int unsigned CFG_RATE_LSB         = 5;
    localparam int unsigned CFG_OVER_POS         = 4;
    localparam int unsigned CFG_UNDER_POS        = 3;
    localparam int unsigned CFG_LATCH_POS        = 2;
    localparam int unsigned CFG_MODE_LSB         = 0;
    // reset values
    localparam logic [7:0]  CONFIG_RESET         = 8'h02;
    localparam logic [7:0]  TEMP_RESET           = 8'h00;
    localparam logic [7:0]  HIGH_RESET           = 8'h3c;
    localparam logic [7:0]  LOW_RESET            = 8'hf6;
    // modes
    localparam logic [1:0]  MODE_SHUTDOWN        = 2'h0;
    localparam logic [1:0]  MODE_ONE_SHOT        = 2'h1;
    // timing
    localparam int unsigned CONV_TIME_MS         = 26;
    localparam int unsigned CONV_CYCLES          = CONV_TIME_MS * (CLOCK_HZ / 1000);
    localparam int unsigned PERIOD_RATE0_MS      = 4000;
    localparam int unsigned PERIOD_RATE1_MS      = 1000;
    localparam int unsigned PERIOD_RATE2_MS      = 250;
    localparam int unsigned PERIOD_RATE3_MS      = 125;
    localparam int unsigned PERIOD_RATE0_CYCLES  = PERIOD_RATE0_MS * (CLOCK_HZ / 1000);
    localparam int unsigned PERIOD_RATE1_CYCLES  = PERIOD_RATE1_MS * (CLOCK_HZ / 1000);
    localparam int unsigned PERIOD_RATE2_CYCLES  = PERIOD_RATE2_MS * (CLOCK_HZ / 1000);
    localparam int unsigned PERIOD_RATE3_CYCLES  = PERIOD_RATE3_MS * (CLOCK_HZ / 1000);
    localparam int unsigned BYTE_BITS            = 8;
endpackage

// file: shared/tsense_link_if.sv
// byte link between chain host and one sensor
// assumes both ends share clock_in; framing lies outside this link
`timescale 1ns/1ns
interface tsense_link_if;
    logic       host_valid;
    logic [7:0] host_byte;
    logic       dev_valid;
    logic [7:0] dev_byte;
    logic       dev_passthru;
    modport host (output host_valid, output host_byte,
                  input dev_valid, input dev_byte, input dev_passthru);
    modport device (input host_valid, input host_byte,
                    output dev_valid, output dev_byte, output dev_passthru);
endinterface

// file: rtl/tsense_bit_shifter.sv
// serialises or deserialises one byte, lsb first
// assumes one bit per cycle when shift_in is high
`timescale 1ns/1ns
module tsense_bit_shifter #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    // control
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] load_value_in,
    input  wire logic             shift_in,
    input  wire logic             bit_in,
    // result
    output logic                  bit_out,
    output logic [WIDTH-1:0]      word_out
);
    initial begin
        if (WIDTH < 2) $error("width too small");
    end
    typedef struct packed {
        logic [WIDTH-1:0] word;
    } shifter_state_t;
    shifter_state_t state;
    shifter_state_t next_state;

    always_comb begin
        next_state = state;
        if (load_in) begin
            next_state.word = load_value_in;
        end else if (shift_in) begin
            next_state.word = {bit_in, state.word[WIDTH-1:1]}; // R18
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign bit_out  = state.word[0];
    assign word_out = state.word;
endmodule

// file: rtl/tsense_host_end.sv
// host end: builds individual command bytes and collects read answers
// assumes the device answers a read with one byte on dev_valid
`timescale 1ns/1ns
module tsense_host_end (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // user request
    input  wire logic       req_in,
    input  wire logic [3:0] target_id_in,
    input  wire logic [1:0] register_pointer_in,
    input  wire logic       read_in,
    input  wire logic [7:0] write_data_in,
    // user answer
    output logic            busy_out,
    output logic            read_valid_out,
    output logic [7:0]      read_data_out,
    // link
    tsense_link_if.host     link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_DATA = 2'b01,
        H_WAIT = 2'b11
    } host_phase_t;
    typedef struct packed {
        host_phase_t phase;
        logic        tx_valid;
        logic [7:0]  tx_byte;
        logic [7:0]  pending;
        logic        busy;
        logic        rd_valid;
        logic [7:0]  rd_data;
    } host_state_t;
    host_state_t state;
    host_state_t next_state;

    always_comb begin
        next_state          = state;
        next_state.tx_valid = 1'b0;
        next_state.rd_valid = 1'b0;
        case (state.phase)
            H_IDLE: begin
                if (req_in) begin
                    next_state.tx_valid = 1'b1;
                    next_state.tx_byte  = {1'b0, target_id_in,
                                           register_pointer_in, read_in}; // R1
                    next_state.pending  = write_data_in;
                    next_state.busy     = 1'b1;
                    next_state.phase    = read_in ? H_WAIT : H_DATA;
                end
            end
            H_DATA: begin
                next_state.tx_valid = 1'b1; // R2
                next_state.tx_byte  = state.pending;
                next_state.busy     = 1'b0;
                next_state.phase    = H_IDLE;
            end
            H_WAIT: begin
                if (link.dev_valid) begin
                    next_state.rd_valid = 1'b1;
                    next_state.rd_data  = link.dev_byte; // R3
                    next_state.busy     = 1'b0;
                    next_state.phase    = H_IDLE;
                end
            end
            default: next_state.phase = H_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= '{H_IDLE, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00};
        end else begin
            state <= next_state;
        end
    end

    assign link.host_valid = state.tx_valid;
    assign link.host_byte  = state.tx_byte;
    assign busy_out        = state.busy;
    assign read_valid_out  = state.rd_valid;
    assign read_data_out   = state.rd_data;
endmodule

// file: rtl/tsense_device_end.sv
// device end: register file, flags and conversion sequencing of one sensor
// assumes host bytes arrive whole on the link; converter value is a plain input
//
// How it works
// R1: command byte: scope, id, pointer, selector
// R2: write: next byte goes to matching device
// R3: read: break chain, send register, reconnect
// R4: temperature register holds last result, 1C/lsb
// R5: negative results in twos complement
// R6: temperature reads zero until first result
// R7: config fields fixed, reset value 02
// R8: result above high limit sets over flag
// R9: result below low limit sets under flag
// R10: latched flags hold until any register read
// R11: read clears flags; unlatched in-range clears
// R12: rate bits choose 0.25, 1, 4, 8 Hz
// R13: 26 ms conversion, rate period counted from its start
// R14: conversion starts right after reset
// R15: shutdown finishes conversion then stops
// R16: one-shot converts once, mode returns 00
// R17: upper mode bit converts repeatedly
// R18: register bytes move lsb first
// R19: pointer selects temp, config, low, high
// R20: limits reset to +60 and -10
// R21: writes to temperature register ignored
// R22: period counter reloaded at conversion start
`timescale 1ns/1ns
module tsense_device_end #(
    parameter int unsigned CONV_CYCLES  = tsense_pkg::CONV_CYCLES,
    parameter int unsigned RATE0_CYCLES = tsense_pkg::PERIOD_RATE0_CYCLES,
    parameter int unsigned RATE1_CYCLES = tsense_pkg::PERIOD_RATE1_CYCLES,
    parameter int unsigned RATE2_CYCLES = tsense_pkg::PERIOD_RATE2_CYCLES,
    parameter int unsigned RATE3_CYCLES = tsense_pkg::PERIOD_RATE3_CYCLES
) (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // identity and software reset
    input  wire logic [3:0] device_id_in,
    input  wire logic       soft_reset_in,
    // converter
    input  wire logic [7:0] sample_in,
    output logic            converting_out,
    output logic            conversion_done_out,
    // state for the user side
    output logic [7:0]      temperature_out,
    output logic [7:0]      configuration_out,
    // link
    tsense_link_if.device   link
);
    initial begin
        if (CONV_CYCLES < 1 || RATE3_CYCLES <= CONV_CYCLES) $error("bad timing parameters");
        if (RATE0_CYCLES >= 2**28) $error("period too long for counter");
    end

    typedef enum logic [1:0] {
        L_CMD  = 2'b00,
        L_DATA = 2'b01,
        L_SEND = 2'b11,
        L_SKIP = 2'b10
    } link_phase_t;
    typedef struct packed {
        link_phase_t phase;
        logic [1:0]  ptr;
        logic [3:0]  bit_count;
        logic        tx_valid;
        logic        passthru;
        logic [7:0]  temperature_result;
        logic [7:0]  sensor_configuration;
        logic [7:0]  low_limit;
        logic [7:0]  high_limit;
        logic        converting;
        logic        done;
        logic [27:0] period_count;
    } dev_state_t;
    dev_state_t state;
    dev_state_t next_state;

    logic       shift_load;
    logic [7:0] shift_load_value;
    logic       shift_en;
    logic [7:0] shift_word;
    logic [7:0] selected;
    logic [27:0] rate_cycles;
    logic       window_end;
    logic       conv_end;
    logic       over;
    logic       under;

    // byte sent back on a read
    tsense_bit_shifter #(.WIDTH(tsense_pkg::BYTE_BITS)) tx_shifter (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .load_in       (shift_load),
        .load_value_in (shift_load_value),
        .shift_in      (shift_en),
        .bit_in        (shift_word[0]),
        .bit_out       (),
        .word_out      (shift_word)
    );

    always_comb begin
        case (link.host_byte[tsense_pkg::CMD_PTR_LSB +: 2]) // R19
            tsense_pkg::PTR_TEMP:   selected = state.temperature_result; // R4
            tsense_pkg::PTR_CONFIG: selected = state.sensor_configuration;
            tsense_pkg::PTR_LOW:    selected = state.low_limit;
            default:                selected = state.high_limit;
        endcase
        case (state.sensor_configuration[tsense_pkg::CFG_RATE_LSB +: 2]) // R12
            2'h0:    rate_cycles = 28'(RATE0_CYCLES);
            2'h1:    rate_cycles = 28'(RATE1_CYCLES);
            2'h2:    rate_cycles = 28'(RATE2_CYCLES);
            default: rate_cycles = 28'(RATE3_CYCLES);
        endcase
    end

    assign conv_end   = state.converting && state.period_count == 28'(CONV_CYCLES - 1); // R13
    assign window_end = state.period_count >= rate_cycles - 28'h1;
    assign over       = $signed(sample_in) > $signed(state.high_limit); // R5 R8
    assign under      = $signed(sample_in) < $signed(state.low_limit); // R9

    always_comb begin
        next_state          = state;
        next_state.tx_valid = 1'b0;
        next_state.done     = 1'b0;
        shift_load          = 1'b0;
        shift_load_value    = selected;
        shift_en            = 1'b0;
        // conversion timing
        next_state.period_count = state.period_count + 28'h1;
        if (conv_end) begin
            next_state.converting         = 1'b0;
            next_state.done               = 1'b1;
            next_state.temperature_result = sample_in; // R6
            if (over) next_state.sensor_configuration[tsense_pkg::CFG_OVER_POS] = 1'b1;
            if (under) next_state.sensor_configuration[tsense_pkg::CFG_UNDER_POS] = 1'b1;
            if (!over && !under
                && !state.sensor_configuration[tsense_pkg::CFG_LATCH_POS]) begin // R10
                next_state.sensor_configuration[tsense_pkg::CFG_OVER_POS]  = 1'b0; // R11
                next_state.sensor_configuration[tsense_pkg::CFG_UNDER_POS] = 1'b0;
            end
            if (state.sensor_configuration[1:0] == tsense_pkg::MODE_ONE_SHOT) begin
                next_state.sensor_configuration[1:0] = tsense_pkg::MODE_SHUTDOWN; // R16
            end
        end else if (!state.converting && window_end) begin
            next_state.period_count = state.period_count;
            if (state.sensor_configuration[1]) begin // R15 R17
                next_state.converting   = 1'b1;
                next_state.period_count = 28'h0; // R22
            end
        end
        // link side
        case (state.phase)
            L_CMD: begin
                if (link.host_valid && !link.host_byte[tsense_pkg::CMD_SCOPE_POS]
                    && link.host_byte[tsense_pkg::CMD_ID_LSB +: 4] == device_id_in) begin // R1
                    next_state.ptr = link.host_byte[tsense_pkg::CMD_PTR_LSB +: 2];
                    if (link.host_byte[tsense_pkg::CMD_RW_POS]) begin
                        next_state.passthru  = 1'b0; // R3
                        next_state.bit_count = 4'h0;
                        next_state.phase     = L_SEND;
                        shift_load           = 1'b1;
                        // flags clear on read, but a result landing now wins
                        if (!(conv_end && over))
                            next_state.sensor_configuration[tsense_pkg::CFG_OVER_POS] = 1'b0;
                        if (!(conv_end && under))
                            next_state.sensor_configuration[tsense_pkg::CFG_UNDER_POS] = 1'b0; // R11
                    end else begin
                        next_state.phase = L_DATA; // R2
                    end
                end else if (link.host_valid && !link.host_byte[tsense_pkg::CMD_SCOPE_POS]
                             && !link.host_byte[tsense_pkg::CMD_RW_POS]) begin
                    next_state.phase = L_SKIP; // R2
                end
            end
            L_SKIP: begin
                // data byte of another device's write is not a command
                if (link.host_valid) begin
                    next_state.phase = L_CMD; // R2
                end
            end
            L_DATA: begin
                if (link.host_valid) begin
                    next_state.phase = L_CMD;
                    case (state.ptr)
                        tsense_pkg::PTR_CONFIG: begin
                            next_state.sensor_configuration = link.host_byte; // R7
                            if (link.host_byte[1:0] == tsense_pkg::MODE_ONE_SHOT
                                && !state.converting) begin
                                next_state.converting   = 1'b1; // R16
                                next_state.period_count = 28'h0;
                            end
                            if (conv_end && over)
                                next_state.sensor_configuration[tsense_pkg::CFG_OVER_POS] = 1'b1;
                            if (conv_end && under)
                                next_state.sensor_configuration[tsense_pkg::CFG_UNDER_POS] = 1'b1;
                        end
                        tsense_pkg::PTR_LOW:  next_state.low_limit  = link.host_byte;
                        tsense_pkg::PTR_HIGH: next_state.high_limit = link.host_byte;
                        default: ; // R21
                    endcase
                end
            end
            L_SEND: begin
                shift_en             = 1'b1; // R18
                next_state.bit_count = state.bit_count + 4'h1;
                if (state.bit_count == 4'(tsense_pkg::BYTE_BITS - 1)) begin
                    next_state.tx_valid = 1'b1;
                    next_state.passthru = 1'b1;
                    next_state.phase    = L_CMD;
                end
            end
            default: next_state.phase = L_CMD;
        endcase
        // shutdown: a running conversion still finishes // R15
    end

    always_ff @(posedge clock_in) begin
        if (rst_in || soft_reset_in) begin
            state <= '{L_CMD, 2'h0, 4'h0, 1'b0, 1'b1,
                       tsense_pkg::TEMP_RESET, tsense_pkg::CONFIG_RESET,
                       tsense_pkg::LOW_RESET, tsense_pkg::HIGH_RESET, // R20
                       1'b1, 1'b0, 28'h0}; // R14
        end else begin
            state <= next_state;
        end
    end

    assign link.dev_valid     = state.tx_valid;
    assign link.dev_byte      = shift_word;
    assign link.dev_passthru  = state.passthru;
    assign converting_out     = state.converting;
    assign conversion_done_out = state.done;
    assign temperature_out    = state.temperature_result;
    assign configuration_out  = state.sensor_configuration;
endmodule

// file: verification/tsense_link_checker.sv
// checker on the byte link between the host end and one device end
// assumes a single device whose id is DEV_ID, all on clock_in
`timescale 1ns/1ns
module tsense_link_checker #(
    parameter logic [3:0] DEV_ID = 4'h5
) (
    // clock and reset
    input wire logic       clock_in,
    input wire logic       rst_in,
    // link signals
    input wire logic       host_valid,
    input wire logic [7:0] host_byte,
    input wire logic       dev_valid,
    input wire logic [7:0] dev_byte,
    input wire logic       dev_passthru
);
    logic data_next;
    logic cmd;
    logic wr_cmd;
    logic read_cmd;
    logic other_cmd;
    assign cmd       = host_valid && !data_next;
    assign wr_cmd    = cmd && !host_byte[7] && !host_byte[0];
    assign read_cmd  = cmd && !host_byte[7] && host_byte[6:3] == DEV_ID && host_byte[0];
    assign other_cmd = cmd && (host_byte[7] || host_byte[6:3] != DEV_ID);
    // marks the byte after a write command as data
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            data_next <= 1'b0;
        end else begin
            data_next <= wr_cmd;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence answer_s;
        (!dev_passthru) [*8] ##1 (dev_valid && dev_passthru);
    endsequence
    sequence quiet_s;
        (dev_passthru && !dev_valid) [*8];
    endsequence
    read_answer_a: assert property (read_cmd |=> answer_s)
        else $error("read answer timing wrong");
    answer_cause_a: assert property (dev_valid |-> $past(read_cmd, 9))
        else $error("answer without read command");
    break_cause_a: assert property ($fell(dev_passthru) |-> $past(read_cmd))
        else $error("chain broken without read command");
    other_quiet_a: assert property (other_cmd |=> quiet_s)
        else $error("device answered a foreign command");
    valid_pulse_a: assert property (dev_valid |=> !dev_valid)
        else $error("answer pulse too long");
    byte_hold_a: assert property (dev_valid |=> $stable(dev_byte))
        else $error("answer byte moved");
    write_pair_a: assert property (wr_cmd |=> host_valid)
        else $error("write command without data byte");
    read_quiet_a: assert property (read_cmd |=> (!host_valid) [*8])
        else $error("host sent during answer");
    reset_idle_a: assert property ($fell(rst_in) |-> dev_passthru && !dev_valid && !host_valid)
        else $error("link not idle after reset");
endmodule

// file: verification/tb.sv
// self-checking bench: host end and device end joined by the link
// assumes 10 MHz clock and shortened conversion and period counts
`timescale 1ns/1ns
module tb;
    localparam logic [3:0] DEV = 4'h5;
    localparam logic [7:0] CORNER [7] = '{8'h3c, 8'h3d, 8'hf6, 8'hf5, 8'hff, 8'h80, 8'h7f};
    logic       clock_in;
    logic       rst_in;
    logic       req_in;
    logic [3:0] target_id_in;
    logic [1:0] register_pointer_in;
    logic       read_in;
    logic [7:0] write_data_in;
    logic       busy_out;
    logic       read_valid_out;
    logic [7:0] read_data_out;
    logic       soft_reset_in;
    logic [7:0] sample_in;
    logic       converting_out;
    logic       conversion_done_out;
    logic [7:0] temperature_out;
    logic [7:0] configuration_out;
    logic [7:0] got;
    logic [7:0] s;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         seed;
    int         cycles = 0;
    int         gap;
    int         n;
    tsense_link_if link ();
    tsense_host_end tsense_host_end_inst (.clock_in(clock_in), .rst_in(rst_in),
        .req_in(req_in), .target_id_in(target_id_in),
        .register_pointer_in(register_pointer_in), .read_in(read_in),
        .write_data_in(write_data_in), .busy_out(busy_out), .read_valid_out(read_valid_out),
        .read_data_out(read_data_out), .link(link));
    tsense_device_end #(.CONV_CYCLES(10), .RATE0_CYCLES(320), .RATE1_CYCLES(160),
        .RATE2_CYCLES(80), .RATE3_CYCLES(40)) tsense_device_end_inst (.clock_in(clock_in),
        .rst_in(rst_in), .device_id_in(DEV), .soft_reset_in(soft_reset_in),
        .sample_in(sample_in), .converting_out(converting_out),
        .conversion_done_out(conversion_done_out), .temperature_out(temperature_out),
        .configuration_out(configuration_out), .link(link));
    tsense_link_checker #(.DEV_ID(DEV)) tsense_link_checker_inst (.clock_in(clock_in),
        .rst_in(rst_in), .host_valid(link.host_valid), .host_byte(link.host_byte),
        .dev_valid(link.dev_valid), .dev_byte(link.dev_byte),
        .dev_passthru(link.dev_passthru));
    function automatic int rate_cycles(input logic [1:0] r);
        return 320 >> r;
    endfunction
    function automatic logic [1:0] flags(input logic [7:0] t);
        return {$signed(t) > $signed(8'h3c), $signed(t) < $signed(8'hf6)};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] g, input logic [15:0] e, input string msg);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, g, e);
        end
    endtask
    task automatic xfer(input logic [3:0] id, input logic [1:0] p, input logic rd,
                        input logic [7:0] d);
        @(negedge clock_in);
        req_in = 1'b1;
        target_id_in = id;
        register_pointer_in = p;
        read_in = rd;
        write_data_in = d;
        got = 8'hxx;
        @(negedge clock_in);
        req_in = 1'b0;
        for (int i = 0; i < 30; i++) begin
            @(negedge clock_in);
            if (read_valid_out === 1'b1) got = read_data_out;
            if (busy_out !== 1'b1) break;
        end
        // let a write data byte land before the caller looks
        @(negedge clock_in);
    endtask
    task automatic wait_done(output int c);
        c = 0;
        do begin
            @(negedge clock_in);
            c++;
        end while (conversion_done_out !== 1'b1 && c < 2000);
    endtask
    task automatic idle_check(input int c);
        n = 0;
        repeat (c) begin
            @(negedge clock_in);
            if (conversion_done_out !== 1'b0) n++;
        end
        check(16'(n), 16'h0, "conversion while shut down");
    endtask
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end
    initial begin
        seed = 32'h3f6f;
        rst_in = 1'b1;
        req_in = 1'b0;
        target_id_in = 4'h0;
        register_pointer_in = 2'h0;
        read_in = 1'b0;
        write_data_in = 8'h00;
        soft_reset_in = 1'b0;
        sample_in = 8'h00;
        repeat (10) @(negedge clock_in);
        rst_in = 1'b0;
        @(negedge clock_in);
        check(temperature_out, 8'h00, "temp reset");
        check(configuration_out, 8'h02, "config reset");
        check(converting_out, 1'b1, "start after reset");
        xfer(DEV, tsense_pkg::PTR_HIGH, 1'b1, 8'h00);
        check(got, 8'h3c, "high reset");
        xfer(DEV, tsense_pkg::PTR_LOW, 1'b1, 8'h00);
        check(got, 8'hf6, "low reset");
        xfer(DEV, tsense_pkg::PTR_CONFIG, 1'b0, 8'h62);
        for (int i = 0; i < 12; i++) begin
            s = (i < 7) ? CORNER[i] : 8'($random(seed));
            sample_in = s;
            wait_done(gap);
            @(negedge clock_in);
            check(temperature_out, s, "result");
            check(configuration_out[4:3], flags(s), "flags");
            xfer(DEV, tsense_pkg::PTR_TEMP, 1'b1, 8'h00);
            check(got, s, "temp read");
            check(configuration_out[4:3], 2'h0, "read clears");
        end
        for (int r = 0; r < 4; r++) begin
            xfer(DEV, tsense_pkg::PTR_CONFIG, 1'b0, {1'b0, 2'(r), 5'h02});
            wait_done(gap);
            wait_done(gap);
            wait_done(gap);
            check(16'(gap), 16'(rate_cycles(2'(r))), "period");
        end
        n = 0;
        while (converting_out !== 1'b1 && n < 100) begin
            @(negedge clock_in);
            n++;
        end
        n = 0;
        while (converting_out === 1'b1 && n < 100) begin
            @(negedge clock_in);
            n++;
        end
        check(16'(n), 16'd10, "conversion length");
        xfer(DEV, tsense_pkg::PTR_CONFIG, 1'b0, 8'h66);
        sample_in = 8'h7f;
        wait_done(gap);
        sample_in = 8'h00;
        wait_done(gap);
        @(negedge clock_in);
        check(configuration_out[4], 1'b1, "latched flag");
        xfer(DEV, tsense_pkg::PTR_CONFIG, 1'b1, 8'h00);
        check(got[4], 1'b1, "latched flag read");
        check(configuration_out[4:3], 2'h0, "flag cleared");
        xfer(DEV, tsense_pkg::PTR_CONFIG, 1'b0, 8'h62);
        sample_in = 8'h7f;
        wait_done(gap);
        sample_in = 8'h00;
        wait_done(gap);
        @(negedge clock_in);
        check(configuration_out[4:3], 2'h0, "in range clears");
        xfer(DEV, tsense_pkg::PTR_CONFIG, 1'b0, 8'h60);
        repeat (20) @(negedge clock_in);
        idle_check(200);
        xfer(DEV, tsense_pkg::PTR_TEMP, 1'b0, 8'h55);
        check(temperature_out, 8'h00, "temp write");
        sample_in = 8'he7;
        xfer(DEV, tsense_pkg::PTR_CONFIG, 1'b0, 8'h61);
        check(configuration_out[1:0], 2'h1, "one-shot mode");
        wait_done(gap);
        @(negedge clock_in);
        check(configuration_out[1:0], 2'h0, "one-shot end");
        check(temperature_out, 8'he7, "one-shot result");
        idle_check(100);
        for (int p = 2; p < 4; p++) begin
            s = 8'($random(seed));
            xfer(DEV, 2'(p), 1'b0, s);
            xfer(DEV ^ 4'h1, 2'(p), 1'b0, ~s);
            xfer(DEV, 2'(p), 1'b1, 8'h00);
            check(got, s, "limit write");
        end
        soft_reset_in = 1'b1;
        @(negedge clock_in);
        soft_reset_in = 1'b0;
        @(negedge clock_in);
        check(converting_out, 1'b1, "start after soft reset");
        check(configuration_out, 8'h02, "config soft reset");
        xfer(DEV, tsense_pkg::PTR_HIGH, 1'b1, 8'h00);
        check(got, 8'h3c, "high soft reset");
        results();
    end
endmodule
